//--- verilog/sac_defines.vh
// register map, field positions, reset values and timing codes of the
// successive-approximation converter control block.
// assumes inclusion by bare name from the design files of this block.
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// ----------------------------------------------------------------------
// register indices and word numbers (byte address = index * 4)
// ----------------------------------------------------------------------
`define SAC_IDX_CTRL_ONE 8'h0E
`define SAC_IDX_CTRL_TWO 8'h0F
`define SAC_IDX_RESULT 8'h20
`define SAC_IDX_STATUS 8'h21
`define SAC_WORD_CTRL_ONE 6'h0E
`define SAC_WORD_CTRL_TWO 6'h0F
`define SAC_WORD_RESULT 6'h20
`define SAC_WORD_STATUS 6'h21

// ----------------------------------------------------------------------
// conv_ctrl_one fields
// ----------------------------------------------------------------------
`define SAC_C1_START 7
`define SAC_C1_DISABLE 4
`define SAC_C1_CHAN_HI 3
`define SAC_C1_CHAN_LO 0
`define SAC_C1_KEEP_HI 6
`define SAC_C1_RESET 7'h10

// ----------------------------------------------------------------------
// conv_ctrl_two fields
// ----------------------------------------------------------------------
`define SAC_C2_LADDER 5
`define SAC_C2_TIME_HI 3
`define SAC_C2_TIME_LO 1
`define SAC_C2_KEEP_HI 5
`define SAC_C2_RESET 6'h00

// ----------------------------------------------------------------------
// conv_status fields
// ----------------------------------------------------------------------
`define SAC_ST_END 5
`define SAC_ST_BUSY 4

// ----------------------------------------------------------------------
// conversion time codes and their length in system-clock periods
// ----------------------------------------------------------------------
`define SAC_TC_39 3'h0
`define SAC_TC_78 3'h2
`define SAC_TC_156 3'h3
`define SAC_TC_312 3'h4
`define SAC_TC_624 3'h5
`define SAC_TC_1248 3'h6
`define SAC_CYC_39 11'h027
`define SAC_CYC_78 11'h04E
`define SAC_CYC_156 11'h09C
`define SAC_CYC_312 11'h138
`define SAC_CYC_624 11'h270
`define SAC_CYC_1248 11'h4E0

// ----------------------------------------------------------------------
// bus answers and misc
// ----------------------------------------------------------------------
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`define SAC_CHAN_COUNT 8
`define SAC_MSB_MASK 8'h80
`define SAC_ONE_MASK 8'h01

`endif

//--- verilog/sac_sar_seq.v
// successive-approximation sequencer: sample phase, then eight bit trials.
// assumes a synchronised comparator level and a start pulse on sys_clk.
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_sar_seq #(
   parameter CW = 11
) (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // control
   input wire start,
   input wire abort,
   input wire [CW-1:0] convCycles,
   // analog side
   input wire compHigh,
   output reg sampleHold_q,
   output reg [7:0] dacCode_q,
   // result
   output reg [7:0] result_q,
   output reg done_q
);

   reg run_q;
   reg [CW-1:0] cnt_q;
   reg [2:0] bitIdx_q;
   wire [CW-1:0] convLess;
   wire [CW-1:0] period;
   wire [CW-1:0] sampleLen;
   wire [7:0] bitMask;
   wire [7:0] trialKeep;

   // sampling takes what the trials leave (1 to 8 cycles), so the total
   // stays exact and never wraps when the time is a multiple of eight
   assign convLess = convCycles - 1'b1;
   assign period = convLess >> 3;
   assign sampleLen = convCycles - {period[CW-4:0], 3'h0};
   assign bitMask = `SAC_ONE_MASK << bitIdx_q;
   // comparator high: input above trial level, keep the bit
   assign trialKeep = compHigh ? dacCode_q : (dacCode_q & ~bitMask);

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst || abort) begin
         run_q <= 1'b0;
         sampleHold_q <= 1'b0;
         cnt_q <= {CW{1'b0}};
         bitIdx_q <= 3'h7;
         dacCode_q <= 8'h00;
         done_q <= 1'b0;
         if (rst) begin
            result_q <= 8'h00;
         end
      end else if (start) begin
         run_q <= 1'b1;
         sampleHold_q <= 1'b1;
         cnt_q <= sampleLen - 1'b1;
         bitIdx_q <= 3'h7;
         dacCode_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (run_q) begin
            if (cnt_q != {CW{1'b0}}) begin
               cnt_q <= cnt_q - 1'b1;
            end else if (sampleHold_q) begin
               sampleHold_q <= 1'b0;
               dacCode_q <= `SAC_MSB_MASK;
               cnt_q <= period - 1'b1;
            end else if (bitIdx_q == 3'h0) begin
               result_q <= trialKeep;
               dacCode_q <= trialKeep;
               done_q <= 1'b1;
               run_q <= 1'b0;
            end else begin
               dacCode_q <= trialKeep | (bitMask >> 1);
               bitIdx_q <= bitIdx_q - 1'b1;
               cnt_q <= period - 1'b1;
            end
         end
      end
   end

endmodule // sac_sar_seq

//--- verilog/sac_adc_ctrl.v
// digital control of an 8-bit successive-approximation converter with an
// AXI4-Lite register slave.
// assumes the analog sample-and-hold, ladder and comparator outside, a
// low-power request level on sys_clk and a comparator level from elsewhere.
//
// Overview of operation
// - writing one to start bit begins a conversion; bit clears itself after
// - channel codes 0 to 7 select inputs 0 to 7; other codes select none
// - input-disable bit at position 4: zero enables, one disables inputs
// - low-power modes reset both control registers and block their writes
// - ladder bit zero: connected during conversion; one: always connected
// - time codes give 39, 78, 156, 312, 624, 1248 clock periods
// - result register holds the 8-bit value, msb at bit 7, resets zero
// - reading the result register clears the end flag
// - busy sets at start, clears at finish and on low-power entry
// - end flag zero before and during conversion, one after; flags read-only
// - status bits 7, 6 and 3 to 0 carry no meaning
// - control two bits 6 and 7 read as undefined
// - on completion result, end flag and done event appear together
// - restart before result read clears end flag; old result kept until done
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_adc_ctrl #(
   parameter ADDR_W = 8,
   parameter CW = 11,
   parameter CHANNELS = `SAC_CHAN_COUNT
) (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // axi4-lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // system mode
   input wire lowPowerMode,
   // analog side
   input wire comparatorHigh,
   output wire sampleHold,
   output wire [7:0] dacCode,
   output reg [CHANNELS-1:0] channelSelect_q,
   output reg analogInputEnable_q,
   output reg ladderConnect_q,
   // event
   output reg conversionDoneInterrupt_q
);

   // -------------------------------------------------------------------
   // register state
   // -------------------------------------------------------------------
   reg [6:0] ctrlOne_q;
   reg startBit_q;
   reg [5:0] ctrlTwo_q;
   reg [7:0] result_q;
   reg endFlag_q;
   reg busy_q;
   reg compMeta_q;
   reg compSync_q;
   reg [CW-1:0] convCycles;

   // write channel holding
   reg awHeld_q;
   reg wHeld_q;
   reg [5:0] wrWord_q;
   reg [7:0] wrData_q;
   reg wrLane_q;

   wire doWrite;
   wire [5:0] rdWord;
   wire rdTake;
   wire resultRead;
   wire wrCtrlOne;
   wire wrCtrlTwo;
   wire seqDone;
   wire [7:0] seqResult;
   reg [31:0] rdData;
   reg rdHit;
   reg wrHit;

   // -------------------------------------------------------------------
   // comparator synchroniser
   // -------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst) begin
         compMeta_q <= 1'b0;
         compSync_q <= 1'b0;
      end else begin
         compMeta_q <= comparatorHigh;
         compSync_q <= compMeta_q;
      end
   end

   // -------------------------------------------------------------------
   // axi4-lite write path
   // -------------------------------------------------------------------
   assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

   always @* begin
      case (wrWord_q)
         `SAC_WORD_CTRL_ONE: wrHit = 1'b1;
         `SAC_WORD_CTRL_TWO: wrHit = 1'b1;
         `SAC_WORD_RESULT: wrHit = 1'b1;
         `SAC_WORD_STATUS: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   // writes are dropped while the low-power mode holds
   assign wrCtrlOne = doWrite && wrLane_q && !lowPowerMode &&
                      (wrWord_q == `SAC_WORD_CTRL_ONE);
   assign wrCtrlTwo = doWrite && wrLane_q && !lowPowerMode &&
                      (wrWord_q == `SAC_WORD_CTRL_TWO);

   always @(posedge sys_clk) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         wrWord_q <= 6'h00;
         wrData_q <= 8'h00;
         wrLane_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SAC_RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            wrWord_q <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wrData_q <= s_axi_wdata[7:0];
            wrLane_q <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // axi4-lite read path
   // -------------------------------------------------------------------
   assign rdTake = s_axi_arvalid && s_axi_arready;
   assign rdWord = s_axi_araddr[7:2];
   assign resultRead = rdTake && (rdWord == `SAC_WORD_RESULT);

   always @* begin
      rdData = 32'h0000_0000;
      rdHit = 1'b1;
      case (rdWord)
         `SAC_WORD_CTRL_ONE: rdData[7:0] = {startBit_q, ctrlOne_q};
         // undefined upper bits read as zero
         `SAC_WORD_CTRL_TWO: rdData[7:0] = {2'h0, ctrlTwo_q};
         `SAC_WORD_RESULT: rdData[7:0] = result_q;
         `SAC_WORD_STATUS: begin
            rdData[`SAC_ST_END] = endFlag_q;
            rdData[`SAC_ST_BUSY] = busy_q;
         end
         default: rdHit = 1'b0;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SAC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rdTake;
         if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdHit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst || lowPowerMode) begin
         ctrlOne_q <= `SAC_C1_RESET;
         ctrlTwo_q <= `SAC_C2_RESET;
         startBit_q <= 1'b0;
      end else begin
         // start bit lives one cycle, cleared as the sequencer starts
         startBit_q <= wrCtrlOne && wrData_q[`SAC_C1_START];
         if (wrCtrlOne) begin
            ctrlOne_q <= wrData_q[`SAC_C1_KEEP_HI:0];
         end
         if (wrCtrlTwo) begin
            ctrlTwo_q <= wrData_q[`SAC_C2_KEEP_HI:0];
         end
      end
   end

   // reserved codes fall back to the shortest time
   always @* begin
      case (ctrlTwo_q[`SAC_C2_TIME_HI:`SAC_C2_TIME_LO])
         `SAC_TC_39: convCycles = `SAC_CYC_39;
         `SAC_TC_78: convCycles = `SAC_CYC_78;
         `SAC_TC_156: convCycles = `SAC_CYC_156;
         `SAC_TC_312: convCycles = `SAC_CYC_312;
         `SAC_TC_624: convCycles = `SAC_CYC_624;
         `SAC_TC_1248: convCycles = `SAC_CYC_1248;
         default: convCycles = `SAC_CYC_39;
      endcase
   end

   // -------------------------------------------------------------------
   // status, result and done event
   // -------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rst || lowPowerMode) begin
         busy_q <= 1'b0;
         endFlag_q <= 1'b0;
         result_q <= 8'h00;
         conversionDoneInterrupt_q <= 1'b0;
      end else begin
         conversionDoneInterrupt_q <= seqDone;
         if (seqDone) begin
            result_q <= seqResult;
            endFlag_q <= 1'b1;
            busy_q <= 1'b0;
         end else begin
            if (startBit_q) begin
               busy_q <= 1'b1;
            end
            // completion wins over a clearing read in the same cycle
            if (resultRead || startBit_q) begin
               endFlag_q <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // analog-side controls
   // -------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
         localparam [3:0] CHAN_CODE = ch;
         always @(posedge sys_clk) begin
            if (rst) begin
               channelSelect_q[ch] <= 1'b0;
            end else begin
               // reserved codes have bit 3 set and match no channel
               channelSelect_q[ch] <=
                  (ctrlOne_q[`SAC_C1_CHAN_HI:`SAC_C1_CHAN_LO] ==
                   CHAN_CODE);
            end
         end
      end
   endgenerate

   always @(posedge sys_clk) begin
      if (rst) begin
         analogInputEnable_q <= 1'b0;
         ladderConnect_q <= 1'b0;
      end else begin
         analogInputEnable_q <= !ctrlOne_q[`SAC_C1_DISABLE];
         ladderConnect_q <= ctrlTwo_q[`SAC_C2_LADDER] ||
                            busy_q || startBit_q;
      end
   end

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   sac_sar_seq #(
      .CW(CW)
   ) uSeq (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(startBit_q),
      .abort(lowPowerMode),
      .convCycles(convCycles),
      .compHigh(compSync_q),
      .sampleHold_q(sampleHold),
      .dacCode_q(dacCode),
      .result_q(seqResult),
      .done_q(seqDone)
   );

endmodule // sac_adc_ctrl

//--- testbench/sac_analog_model.sv
// far side of the converter: input mux, ladder and comparator.
// assumes dacCode settles within one sys_clk; each input has a fixed level.
`timescale 1ns/1ps

module sac_analog_model (
   // clock
   input wire sys_clk,
   // from the converter control
   input wire [7:0] channelSelect_q,
   input wire analogInputEnable_q,
   input wire ladderConnect_q,
   input wire [7:0] dacCode,
   // to the converter control
   output logic comparatorHigh
);
   logic [7:0] vin;
   logic floatPattern_q = 1'b0;

   // no input selected or inputs disabled reads as ground
   always_comb begin
      vin = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (channelSelect_q[i] && analogInputEnable_q)
            vin = 8'h17 + 8'h1D * 8'(i);
      end
   end

   // a disconnected ladder leaves the comparator chattering
   always @(posedge sys_clk) begin
      floatPattern_q <= ~floatPattern_q;
   end
   assign comparatorHigh = ladderConnect_q ? (vin >= dacCode) : floatPattern_q;
endmodule // sac_analog_model

//--- testbench/sac_adc_ctrl_assertions.sv
// port-level checks of the converter control, bound to its top module.
// assumes sys_clk with rst synchronous and active high.
`timescale 1ns/1ps

module sac_adc_ctrl_assertions #(
   parameter CHANNELS = 8
) (
   // clock and reset
   input logic sys_clk,
   input logic rst,
   // bus answers
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [31:0] s_axi_rdata,
   input logic s_axi_rvalid,
   // mode and analog side
   input logic lowPowerMode,
   input logic sampleHold,
   input logic [7:0] dacCode,
   input logic [CHANNELS-1:0] channelSelect_q,
   input logic ladderConnect_q,
   input logic conversionDoneInterrupt_q
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------
   // conversion timeline
   // ------------------------------
   sequence s_sampleStart;
      $rose(sampleHold);
   endsequence
   sequence s_firstTrial;
      ##[0:2] (dacCode == 8'h80);
   endsequence

   // cycles since the sample phase opened, saturating; long times exceed
   // any delay range, so the length is counted here
   logic holdSeen_q;
   logic [11:0] sinceSample_q;
   always @(posedge sys_clk) begin
      holdSeen_q <= sampleHold;
      if (rst || (sampleHold && !holdSeen_q)) begin
         sinceSample_q <= 12'h000;
      end else if (sinceSample_q != 12'hFFF) begin
         sinceSample_q <= sinceSample_q + 12'h001;
      end
   end

   property p_donePulse;
      conversionDoneInterrupt_q |=> !conversionDoneInterrupt_q;
   endproperty
   a_donePulse: assert property (p_donePulse)
      else $error("done event longer than one cycle");
   property p_convTime;
      conversionDoneInterrupt_q |-> sinceSample_q inside {12'h027, 12'h04E,
         12'h09C, 12'h138, 12'h270, 12'h4E0};
   endproperty
   a_convTime: assert property (p_convTime)
      else $error("conversion length not a selectable time");
   property p_noEarlyDone;
      s_sampleStart |-> !conversionDoneInterrupt_q [*8];
   endproperty
   a_noEarlyDone: assert property (p_noEarlyDone)
      else $error("conversion ended during sampling");
   property p_msbFirst;
      $fell(sampleHold) && !lowPowerMode |-> s_firstTrial;
   endproperty
   a_msbFirst: assert property (p_msbFirst)
      else $error("first trial is not the top bit");
   property p_sampleLadder;
      sampleHold |-> ladderConnect_q;
   endproperty
   a_sampleLadder: assert property (p_sampleLadder)
      else $error("ladder open while sampling");
   property p_chanOneHot;
      $onehot0(channelSelect_q);
   endproperty
   a_chanOneHot: assert property (p_chanOneHot)
      else $error("more than one input selected");
   property p_lowPowerIdle;
      lowPowerMode [*3] |-> !ladderConnect_q && channelSelect_q == 1;
   endproperty
   a_lowPowerIdle: assert property (p_lowPowerIdle)
      else $error("controls not back to initial in low power");
   property p_oneResp;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_bresp[0] == 0;
   endproperty
   a_oneResp: assert property (p_oneResp)
      else $error("write answer repeated");
   property p_byteLane;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_byteLane: assert property (p_byteLane)
      else $error("read data outside byte lane zero");
endmodule // sac_adc_ctrl_assertions

bind sac_adc_ctrl sac_adc_ctrl_assertions #(.CHANNELS(CHANNELS)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .lowPowerMode(lowPowerMode), .sampleHold(sampleHold), .dacCode(dacCode),
   .channelSelect_q(channelSelect_q), .ladderConnect_q(ladderConnect_q),
   .conversionDoneInterrupt_q(conversionDoneInterrupt_q)
);

//--- testbench/sac_adc_ctrl_tb.sv
// bench for the converter control: bus tasks, conversions, low power.
// assumes the far-side model sac_analog_model and the bound checker.
`timescale 1ns/1ps
`include "sac_defines.vh"

module sac_adc_ctrl_tb;
   localparam [7:0] A_C1 = `SAC_IDX_CTRL_ONE << 2;
   localparam [7:0] A_C2 = `SAC_IDX_CTRL_TWO << 2;
   localparam [7:0] A_RES = `SAC_IDX_RESULT << 2;
   localparam [7:0] A_ST = `SAC_IDX_STATUS << 2;
   localparam [1:0] OK = `SAC_RESP_OKAY;
   localparam int LIMIT = 20000;
   int tcy[8] = '{39, 39, 78, 156, 312, 624, 1248, 39};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic lowPowerMode = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire sampleHold, comparatorHigh, inEn, ladderOn, doneEvt;
   wire [7:0] dacCode, chanSel;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;

   sac_adc_ctrl dut (
      .sys_clk(sys_clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lowPowerMode(lowPowerMode),
      .comparatorHigh(comparatorHigh), .sampleHold(sampleHold),
      .dacCode(dacCode), .channelSelect_q(chanSel),
      .analogInputEnable_q(inEn), .ladderConnect_q(ladderOn),
      .conversionDoneInterrupt_q(doneEvt)
   );
   sac_analog_model u_analog (
      .sys_clk(sys_clk), .channelSelect_q(chanSel),
      .analogInputEnable_q(inEn), .ladderConnect_q(ladderOn),
      .dacCode(dacCode), .comparatorHigh(comparatorHigh)
   );

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // ------------------------------
   // checks and bus tasks
   // ------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         $display("BAD %0t run did not finish", $time);
         fails++;
         end_sim();
      end
   end

   function automatic logic [7:0] lvl(input int ch);
      return 8'h17 + 8'h1D * ch[7:0];
   endfunction

   task automatic chkData(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t data %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t answer %h expected %h", $time, got, exp);
      end
   endtask

   // two edges after the answer so the ports have settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] er);
      logic got;
      logic [1:0] r;
      got = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            r = bresp;
            got = 1'b1;
         end
      end
      repeat (2) @(posedge sys_clk);
      chkResp(r, er);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d,
         output logic [1:0] r);
      logic got;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            d = rdata[7:0];
            r = rresp;
            got = 1'b1;
         end
      end
      @(posedge sys_clk);
   endtask

   task automatic chkReg(input logic [7:0] a, input logic [7:0] e,
         input logic [7:0] m);
      logic [7:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chkResp(r, OK);
      chkData(d & m, e & m);
   endtask

   task automatic waitDone();
      while (doneEvt !== 1'b1)
         @(posedge sys_clk);
   endtask

   // ------------------------------
   // test sequence
   // ------------------------------
   initial begin
      int t0;
      int el;
      logic [7:0] d;
      logic [1:0] r;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chkReg(A_C1, 8'h10, 8'hFF);
      chkReg(A_C2, 8'h00, 8'h3F);
      chkReg(A_RES, 8'h00, 8'hFF);
      chkReg(A_ST, 8'h00, 8'h30);
      wr(8'h40, 8'h11, `SAC_RESP_SLVERR);
      rd(8'h44, d, r);
      chkResp(r, `SAC_RESP_SLVERR);
      wr(A_RES, 8'h55, OK);
      chkReg(A_RES, 8'h00, 8'hFF);
      for (int c = 0; c < 16; c++) begin
         wr(A_C1, 8'h20 | c[7:0], OK);
         chkData(chanSel, (c < 8) ? 8'h01 << c : 8'h00);
         chkData({7'h00, inEn}, 8'h01);
      end
      wr(A_C1, 8'h33, OK);
      chkData({7'h00, inEn}, 8'h00);
      // every time code, each on its own input
      for (int c = 0; c < 8; c++) begin
         wr(A_C2, 8'h10 | (c[7:0] << 1), OK);
         wr(A_C1, 8'hA0 | c[7:0], OK);
         t0 = cyc;
         chkData({7'h00, ladderOn}, 8'h01);
         chkReg(A_C1, 8'h20 | c[7:0], 8'hFF);
         chkReg(A_ST, 8'h10, 8'h30);
         waitDone();
         el = cyc - t0 - tcy[c];
         chkData({7'h00, el >= -2 && el <= 6}, 8'h01);
         chkReg(A_ST, 8'h20, 8'h30);
         chkData({7'h00, ladderOn}, 8'h00);
         chkReg(A_RES, lvl(c), 8'hFF);
         chkReg(A_ST, 8'h00, 8'h30);
      end
      wr(A_C1, 8'hB3, OK);
      waitDone();
      chkReg(A_RES, 8'h00, 8'hFF);
      // restart before the result is read
      wr(A_C1, 8'hA1, OK);
      waitDone();
      wr(A_C1, 8'hA2, OK);
      chkReg(A_ST, 8'h10, 8'h30);
      chkReg(A_RES, lvl(1), 8'hFF);
      waitDone();
      chkReg(A_RES, lvl(2), 8'hFF);
      wr(A_C2, 8'h38, OK);
      chkData({7'h00, ladderOn}, 8'h01);
      chkReg(A_C2, 8'h38, 8'h3F);
      // low power in mid conversion
      wr(A_C1, 8'hA5, OK);
      repeat (20) @(posedge sys_clk);
      lowPowerMode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chkReg(A_C1, 8'h10, 8'hFF);
      chkReg(A_C2, 8'h00, 8'h3F);
      chkReg(A_ST, 8'h00, 8'h30);
      wr(A_C1, 8'h23, OK);
      chkReg(A_C1, 8'h10, 8'hFF);
      lowPowerMode <= 1'b0;
      @(posedge sys_clk);
      wr(A_C1, 8'h23, OK);
      chkReg(A_C1, 8'h23, 8'hFF);
      end_sim();
   end
endmodule // sac_adc_ctrl_tb
